// *** sbg_serial.sv ***
`timescale 1ns/10ps
`default_nettype none

// Notes on behaviour
// RULE_01: Mode 0 bit rate is oscillator/12.
// RULE_02: Mode 2 rate osc/64, or osc/32 doubled.
// RULE_03: Internal generator divides oscillator by 78.
// RULE_04: Doubler removes divide-by-two: osc*2^d/2496.
// RULE_05: Baud clock divided by sixteen in port.
// RULE_06: Timer source: overflow*2^d/32.
// RULE_07: Generator select is control bit 7.
// RULE_08: Software sets timer as 8-bit auto-reload.
// RULE_09: Mode 0 moves eight bits LSB first.
// RULE_10: Buffer write loads marker into ninth bit.
// RULE_11: One machine cycle before transmit-active.
// RULE_12: Transmit drives data and shift clock pins.
// RULE_13: Shift clock low S3-S5, high S6-S2.
// RULE_14: Shift right at S6P2, zeros from left.
// RULE_15: Final shift, done flag at S1P1 cycle ten.
// RULE_16: Receive starts on enable, loads FE.
// RULE_17: Receive clock toggles at S3P1, S6P1.
// RULE_18: Shift left at S6P2, S5P2 sample in.
// RULE_19: Last shift loads buffer, sets done flag.
// RULE_20: Generator select clear after reset.
// RULE_21: Port divides x16 baud clock by sixteen.
// RULE_22: Machine cycle is six states, two phases.
module sbg_serial (
  // Clock and reset
  input  wire logic           ref_clk,
  input  wire logic           rst_n,
  // Configuration
  input  wire sbg_pkg::sbg_mode_t serial_mode,
  input  wire logic [7:0]     analog_serial_control_reg,
  input  wire logic           rate_doubler_bit,
  input  wire logic           timer_overflow,
  input  wire logic           receiver_enable,
  // Buffer write and flag clears
  input  wire logic           serial_buffer_wr,
  input  wire logic [7:0]     serial_buffer_wdata,
  output logic                serial_buffer_wr_ready,
  input  wire logic           transmit_done_clr,
  input  wire logic           receive_done_clr,
  // Received bytes
  output logic                rx_valid,
  output logic [7:0]          rx_data,
  input  wire logic           rx_ready,
  // Status
  output logic                transmit_done_flag,
  output logic                receive_done_flag,
  output logic                baud_tick,
  // Pins: data pin three-way, shift clock out
  input  wire logic           data_pin_i,
  output logic                data_pin_o,
  output logic                data_pin_oe,
  output logic                shift_clk_o
);
  import sbg_pkg::*;

  sbg_regs_t r_reg;
  sbg_regs_t r_next;
  logic      gen_sel;
  logic      m0;
  logic      x16_src;
  logic      push;
  logic      pop;
  logic [7:0] rx_byte;
  logic      clk_fall;
  logic      clk_rise;

  // Select reads as clear while reset is held
  assign gen_sel = rst_n ? analog_serial_control_reg[SBG_GEN_SEL_BIT]
                         : SBG_GEN_SEL_RST; // [RULE_07] [RULE_20]
  assign m0      = (serial_mode == SBG_MODE0);
  // Pin is registered, so each clock edge is decided one phase early
  assign clk_fall = (r_reg.phase == SBG_S3P1 - 4'h1);
  assign clk_rise = (r_reg.phase == SBG_S6P1 - 4'h1);

  // Outputs come straight from the state register
  assign serial_buffer_wr_ready = r_reg.wr_ready;
  assign rx_valid           = r_reg.buf_v0;
  assign rx_data            = r_reg.buf_q0;
  assign transmit_done_flag = r_reg.tx_done;
  assign receive_done_flag  = r_reg.rx_done;
  assign baud_tick          = r_reg.bit_tick;
  assign data_pin_o         = r_reg.pins.data_o;
  assign data_pin_oe        = r_reg.pins.data_oe;
  assign shift_clk_o        = r_reg.pins.clk_o;

  // Next state of everything
  always_comb begin
    r_next          = r_reg;
    push            = 1'b0;
    rx_byte         = 8'h00;
    x16_src         = 1'b0;
    r_next.bit_tick = 1'b0;
    r_next.x16_tick = 1'b0;

    // Phase counter, one ref_clk per phase, twelve per cycle
    if (r_reg.phase == SBG_PHASE_LAST) begin // [RULE_22]
      r_next.phase = 4'h0;
    end else begin
      r_next.phase = r_reg.phase + 4'h1;
    end

    // Prescaler /78 then optional /2 removed by doubler
    if (r_reg.gen_cnt == SBG_GEN_LAST) begin // [RULE_03]
      r_next.gen_cnt  = 7'h00;
      r_next.gen_half = ~r_reg.gen_half;
    end else begin
      r_next.gen_cnt = r_reg.gen_cnt + 7'h01;
    end
    // Timer overflow halved unless doubled
    if (timer_overflow) begin
      r_next.tmr_half = ~r_reg.tmr_half;
    end
    // Mode 2 /64 or /32 count
    r_next.m2_cnt = r_reg.m2_cnt + 6'h01;

    // Select the x16 baud clock source
    case (serial_mode)
      SBG_MODE2: begin
        // Doubler halves the period [RULE_02]
        x16_src = rate_doubler_bit ? (r_reg.m2_cnt[4:0] == 5'h1F)
                                   : (r_reg.m2_cnt == SBG_M2_LAST);
      end
      SBG_MODE1, SBG_MODE3: begin
        if (gen_sel) begin
          x16_src = (r_reg.gen_cnt == SBG_GEN_LAST) &&
                    (rate_doubler_bit || r_reg.gen_half); // [RULE_04]
        end else begin
          x16_src = timer_overflow &&
                    (rate_doubler_bit || r_reg.tmr_half); // [RULE_06]
        end
      end
      default: x16_src = 1'b0;
    endcase
    // Mode 2 divider already yields the bit period; modes 1 and 3 /16
    if (serial_mode == SBG_MODE2) begin
      r_next.bit_tick = x16_src;
    end else if (x16_src) begin
      r_next.x16_tick = 1'b1;
      r_next.x16_cnt  = r_reg.x16_cnt + 4'h1;
      r_next.bit_tick = (r_reg.x16_cnt == SBG_X16_LAST); // [RULE_05] [RULE_21]
    end
    if (m0) begin
      r_next.bit_tick = (r_reg.phase == SBG_S6P2); // [RULE_01]
    end

    // Set wins over clear on both flags
    if (transmit_done_clr) r_next.tx_done = 1'b0;
    if (receive_done_clr)  r_next.rx_done = 1'b0;

    // Mode 0 controller
    case (r_reg.state)
      SBG_IDLE: begin
        r_next.wr_ready = 1'b1;
        if (m0 && serial_buffer_wr && r_reg.wr_ready &&
            r_reg.phase == SBG_S6P2) begin
          r_next.tx_sr    = {1'b1, serial_buffer_wdata}; // [RULE_10]
          r_next.state    = SBG_TWAIT;
          r_next.wr_ready = 1'b0;
        end else if (m0 && receiver_enable && !r_reg.rx_done &&
                     !receive_done_clr && !r_reg.buf_v1) begin
          r_next.state    = SBG_RWAIT; // [RULE_16]
          r_next.wr_ready = 1'b0;
        end
      end
      SBG_TWAIT: begin
        // A full machine cycle passes before sending
        if (r_reg.phase == SBG_S6P2) begin // [RULE_11]
          r_next.state        = SBG_SEND;
          r_next.pins.data_oe = 1'b1;
          r_next.pins.data_o  = r_reg.tx_sr[0];
        end
      end
      SBG_SEND: begin
        r_next.pins.data_oe = 1'b1;
        r_next.pins.data_o  = r_reg.tx_sr[0]; // [RULE_12] [RULE_09]
        if (clk_fall) r_next.pins.clk_o = 1'b0; // [RULE_13]
        if (clk_rise) r_next.pins.clk_o = 1'b1; // [RULE_13]
        if (r_reg.phase == SBG_S6P2) begin
          r_next.tx_sr = {1'b0, r_reg.tx_sr[8:1]}; // [RULE_14]
          // Marker next to the MSB; the MSB itself may be either value
          if ((r_reg.tx_sr | 9'h001) == SBG_TX_END) begin
            // Finish lands on S1P1 of the tenth cycle
            r_next.state        = SBG_IDLE; // [RULE_15]
            r_next.tx_done      = 1'b1;
            r_next.pins.data_oe = 1'b0;
            r_next.pins.clk_o   = 1'b1;
          end
        end
      end
      SBG_RWAIT: begin
        if (r_reg.phase == SBG_S6P2) begin
          r_next.rx_sr = SBG_RX_INIT; // [RULE_16]
          r_next.state = SBG_RECV;
        end
      end
      SBG_RECV: begin
        if (clk_fall) r_next.pins.clk_o = 1'b0; // [RULE_17]
        if (clk_rise) r_next.pins.clk_o = 1'b1; // [RULE_17]
        if (r_reg.phase == SBG_S5P2) r_next.rx_sample = data_pin_i;
        if (r_reg.phase == SBG_S6P2) begin
          r_next.rx_sr = {r_reg.rx_sr[6:0], r_reg.rx_sample}; // [RULE_18]
          if (!r_reg.rx_sr[7]) begin
            // Byte arrives LSB first, so reverse bit order
            rx_byte      = {<<{r_reg.rx_sr[6:0], r_reg.rx_sample}};
            push         = 1'b1; // [RULE_19]
            r_next.state = SBG_IDLE;
            r_next.rx_done = 1'b1; // [RULE_19]
          end
        end
      end
      default: begin
        r_next.state = SBG_IDLE;
      end
    endcase
    if (!m0 && r_reg.state != SBG_IDLE) begin
      // Leaving mode 0 aborts the byte in flight
      r_next.state        = SBG_IDLE;
      r_next.pins.data_oe = 1'b0;
      r_next.pins.clk_o   = 1'b1;
    end

    // Two-entry output buffer; receive is held off while full
    pop = r_reg.buf_v0 && rx_ready;
    if (pop) begin
      r_next.buf_q0 = r_reg.buf_q1;
      r_next.buf_v0 = r_reg.buf_v1;
      r_next.buf_v1 = 1'b0;
    end
    if (push) begin
      if (!r_next.buf_v0) begin
        r_next.buf_q0 = rx_byte;
        r_next.buf_v0 = 1'b1;
      end else begin
        r_next.buf_q1 = rx_byte;
        r_next.buf_v1 = 1'b1;
      end
    end
  end

  // State register, synchronous reset
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      r_reg           <= '0;
      r_reg.state     <= SBG_IDLE;
      r_reg.pins.clk_o <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

endmodule
`default_nettype wire

// *** sbg_pkg.sv ***
package sbg_pkg;

  // Machine cycle: six states, two phases each, one phase per ref_clk
  localparam int unsigned SBG_PHASES_PER_CYCLE = 12;
  localparam logic [3:0]  SBG_PHASE_LAST       = 4'hB;
  // Phase index: S1P1=0, S1P2=1, ... S6P2=11
  localparam logic [3:0]  SBG_S1P1             = 4'h0;
  localparam logic [3:0]  SBG_S3P1             = 4'h4;
  localparam logic [3:0]  SBG_S5P2             = 4'h9;
  localparam logic [3:0]  SBG_S6P1             = 4'hA;
  localparam logic [3:0]  SBG_S6P2             = 4'hB;

  // Rate dividers, in oscillator periods; the timer one in overflows, the port one in x16 ticks
  localparam int unsigned SBG_MODE2_DIV        = 64;
  localparam int unsigned SBG_GEN_DIV          = 78;
  localparam int unsigned SBG_GEN_FINAL_DIV    = 2496;
  localparam int unsigned SBG_TMR_DIV          = 32;
  localparam int unsigned SBG_PORT_DIV         = 16;
  localparam logic [6:0]  SBG_GEN_LAST         = 7'h4D;
  localparam logic [5:0]  SBG_M2_LAST          = 6'h3F;
  localparam logic [3:0]  SBG_X16_LAST         = 4'hF;

  // Control register bit position and reset values
  localparam int unsigned SBG_GEN_SEL_BIT      = 7;
  localparam logic        SBG_GEN_SEL_RST      = 1'b0;
  localparam logic        SBG_DOUBLER_RST      = 1'b0;

  // Shift register constants
  localparam logic [8:0]  SBG_TX_MARK          = 9'h100;
  localparam logic [7:0]  SBG_RX_INIT          = 8'hFE;
  localparam logic [8:0]  SBG_TX_END           = 9'h003;

  // Serial modes
  typedef enum logic [1:0] {
    SBG_MODE0 = 2'h0,
    SBG_MODE1 = 2'h1,
    SBG_MODE2 = 2'h2,
    SBG_MODE3 = 2'h3
  } sbg_mode_t;

  // Mode 0 controller states, one-hot
  typedef enum logic [4:0] {
    SBG_IDLE  = 5'h01,
    SBG_TWAIT = 5'h02,
    SBG_SEND  = 5'h04,
    SBG_RWAIT = 5'h08,
    SBG_RECV  = 5'h10
  } sbg_state_t;

  // Pin group
  typedef struct packed {
    logic data_o;
    logic data_oe;
    logic clk_o;
  } sbg_pins_t;

  // Whole state of the block
  typedef struct packed {
    sbg_state_t state;
    logic [3:0] phase;
    logic [6:0] gen_cnt;
    logic       gen_half;
    logic [5:0] m2_cnt;
    logic       tmr_half;
    logic [3:0] x16_cnt;
    logic       x16_tick;
    logic       bit_tick;
    logic [8:0] tx_sr;
    logic [7:0] rx_sr;
    logic       rx_sample;
    logic       tx_done;
    logic       rx_done;
    logic [7:0] buf_q0;
    logic [7:0] buf_q1;
    logic       buf_v0;
    logic       buf_v1;
    logic       wr_ready;
    sbg_pins_t  pins;
  } sbg_regs_t;

endpackage

// *** sbg_properties.sv ***
`timescale 1ns/10ps
`default_nettype none
// Port-level checks on the mode 0 shifter and the rate ticks
module sbg_chk (
  // Clock and reset
  input wire logic               ref_clk,
  input wire logic               rst_n,
  // Watched ports
  input wire sbg_pkg::sbg_mode_t serial_mode,
  input wire logic               rate_doubler_bit,
  input wire logic               serial_buffer_wr,
  input wire logic               serial_buffer_wr_ready,
  input wire logic               transmit_done_flag,
  input wire logic               receive_done_flag,
  input wire logic               rx_valid,
  input wire logic               baud_tick,
  input wire logic               data_pin_o,
  input wire logic               data_pin_oe,
  input wire logic               shift_clk_o
);
  import sbg_pkg::*;
  // One clock domain, so one default clock and reset
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  a_send_after_cycle: assert property (
    $fell(serial_buffer_wr_ready) && $past(serial_buffer_wr)
    |-> ##12 $rose(data_pin_oe)) else $error("send start off");
  a_mode0_rate: assert property (
    baud_tick && serial_mode == SBG_MODE0
    |-> ##12 (baud_tick || serial_mode != SBG_MODE0))
    else $error("mode 0 tick spacing");
  a_mode2_rate: assert property (
    baud_tick && serial_mode == SBG_MODE2 && !rate_doubler_bit
    |-> ##64 (baud_tick || serial_mode != SBG_MODE2 || rate_doubler_bit))
    else $error("mode 2 tick spacing");
  a_clk_low_span: assert property (
    $fell(shift_clk_o) |-> !shift_clk_o[*6] ##1 shift_clk_o)
    else $error("shift clock low span");
  a_clk_high_span: assert property (
    $rose(shift_clk_o) |-> shift_clk_o[*6])
    else $error("shift clock high span");
  a_data_edge: assert property (
    data_pin_oe && $past(data_pin_oe) && $changed(data_pin_o)
    |-> shift_clk_o) else $error("data moved with clock low");
  a_done_ends_send: assert property (
    $rose(transmit_done_flag) |-> $fell(data_pin_oe))
    else $error("done flag apart from send end");
  a_rx_push: assert property (
    $rose(receive_done_flag) |-> ##[0:1] rx_valid)
    else $error("received byte not buffered");
endmodule
bind sbg_serial sbg_chk u_chk (
  .ref_clk(ref_clk), .rst_n(rst_n), .serial_mode(serial_mode),
  .rate_doubler_bit(rate_doubler_bit), .serial_buffer_wr(serial_buffer_wr),
  .serial_buffer_wr_ready(serial_buffer_wr_ready),
  .transmit_done_flag(transmit_done_flag),
  .receive_done_flag(receive_done_flag), .rx_valid(rx_valid),
  .baud_tick(baud_tick), .data_pin_o(data_pin_o),
  .data_pin_oe(data_pin_oe), .shift_clk_o(shift_clk_o)
);
`default_nettype wire

// *** sbg_ext_shreg.sv ***
`timescale 1ns/10ps
`default_nettype none
// Plain 8-bit shift register clocked by the device's shift clock
module sbg_ext_shreg (
  // Pin side
  input  wire logic       shift_clk,
  input  wire logic       pin_level,
  input  wire logic       dev_drives,
  output logic            ext_bit,
  // Test side
  input  wire logic       load,
  input  wire logic [7:0] load_byte,
  output logic [7:0]      got_byte
);
  logic [7:0] out_q;
  logic [3:0] cnt_q;
  assign ext_bit = out_q[0];
  // Rising clock moves both ways; idle bits are inverted, never stale
  always @(posedge shift_clk or posedge load) begin
    if (load) begin
      out_q <= load_byte;
      cnt_q <= 4'h0;
    end else begin
      out_q <= {~out_q[0], out_q[7:1]};
      if (dev_drives && cnt_q < 4'h8) begin
        got_byte <= {pin_level, got_byte[7:1]};
        cnt_q    <= cnt_q + 4'h1;
      end
    end
  end
endmodule
`default_nettype wire

// *** tb_sbg.sv ***
`timescale 1ns/10ps
`default_nettype none
module tb;
  import sbg_pkg::*;
  // Stimulus
  logic       ref_clk = 1'b0;
  logic       rst_n   = 1'b0;
  sbg_mode_t  mode    = SBG_MODE0;
  logic [7:0] ctl     = 8'h00;
  logic [7:0] wdat    = 8'h00;
  logic [7:0] ld_byte = 8'h00;
  logic       dbl = 1'b0, ovf = 1'b0, ren = 1'b0, wr = 1'b0;
  logic       tclr = 1'b0, rclr = 1'b0, rrdy = 1'b0, ld = 1'b0;
  logic [1:0] oc      = 2'h0;
  // Observed
  logic       wrdy, rxv, tdf, rdf, tick, dout, doe, sclk, ext, pin;
  logic [7:0] rxd, got;
  int         error_cnt    = 0;
  int         total_checks = 0;
  // Clock, overflow every fourth cycle, shared data pin
  always #10 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    oc  <= oc + 2'h1;
    ovf <= (oc == 2'h3);
  end
  assign pin = doe ? dout : ext;
  sbg_serial DUT (
    .ref_clk(ref_clk), .rst_n(rst_n), .serial_mode(mode),
    .analog_serial_control_reg(ctl), .rate_doubler_bit(dbl),
    .timer_overflow(ovf), .receiver_enable(ren),
    .serial_buffer_wr(wr), .serial_buffer_wdata(wdat),
    .serial_buffer_wr_ready(wrdy), .transmit_done_clr(tclr),
    .receive_done_clr(rclr), .rx_valid(rxv), .rx_data(rxd),
    .rx_ready(rrdy), .transmit_done_flag(tdf),
    .receive_done_flag(rdf), .baud_tick(tick), .data_pin_i(pin),
    .data_pin_o(dout), .data_pin_oe(doe), .shift_clk_o(sclk)
  );
  sbg_ext_shreg u_ext (
    .shift_clk(sclk), .pin_level(pin), .dev_drives(doe),
    .ext_bit(ext), .load(ld), .load_byte(ld_byte), .got_byte(got)
  );
  task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic close_out();
    if (error_cnt == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Bounded wait for a flag; the caller's compare catches a timeout
  task automatic wt(ref logic s, input int n);
    for (int i = 0; i < n && s !== 1'b1; i++) @(posedge ref_clk);
  endtask
  task automatic tx(input logic [7:0] b);
    ld <= 1'b1;
    @(posedge ref_clk);
    ld <= 1'b0;
    wt(wrdy, 50);
    wr   <= 1'b1;
    wdat <= b;
    @(posedge ref_clk);
    wt_low: for (int i = 0; i < 20 && wrdy === 1'b1; i++) @(posedge ref_clk);
    wr <= 1'b0;
    repeat (11) @(posedge ref_clk);
    chk("tx oe wait", 1'b0, doe);
    @(posedge ref_clk);
    chk("tx oe start", 1'b1, doe);
    wt(tdf, 150);
    chk("tx flag", 1'b1, tdf);
    chk("tx oe end", 1'b0, doe);
    chk("tx byte", b, got);
    tclr <= 1'b1;
    @(posedge ref_clk);
    tclr <= 1'b0;
    repeat (2) @(posedge ref_clk);
    chk("tx flag clr", 1'b0, tdf);
    chk("tx ready", 1'b1, wrdy);
  endtask
  task automatic rx(input logic [7:0] b);
    ld_byte <= b;
    ld      <= 1'b1;
    @(posedge ref_clk);
    ld  <= 1'b0;
    ren <= 1'b1;
    wt(rdf, 150);
    ren <= 1'b0;
    chk("rx flag", 1'b1, rdf);
    rclr <= 1'b1;
    @(posedge ref_clk);
    rclr <= 1'b0;
    @(posedge ref_clk);
  endtask
  // Fill both entries, see the third refused, then drain
  task automatic rx_buf();
    rx(8'h96);
    rx(8'h3B);
    ren <= 1'b1;
    repeat (240) @(posedge ref_clk);
    chk("rx refused", 1'b0, rdf);
    ren <= 1'b0;
    chk("rx head", 8'h96, rxd);
    for (int i = 0; i < 2; i++) begin
      rrdy <= 1'b1;
      @(posedge ref_clk);
      rrdy <= 1'b0;
      @(posedge ref_clk);
      if (i == 0) chk("rx next", 8'h3B, rxd);
    end
    chk("rx empty", 1'b0, rxv);
  endtask
  task automatic rate(sbg_mode_t m, logic g, logic d, int p);
    int n;
    mode <= m;
    ctl  <= {g, 7'h00};
    dbl  <= d;
    wt(tick, 3000);
    @(posedge ref_clk);
    wt(tick, 3000);
    @(posedge ref_clk);
    n = 1;
    while (tick !== 1'b1 && n < 3000) begin
      @(posedge ref_clk);
      n++;
    end
    chk("tick period", p, n);
  endtask
  // Main sequence
  initial begin
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge ref_clk);
    chk("shift clk idle", 1'b1, sclk);
    tx(8'hA5);
    tx(8'h3C);
    rx_buf();
    rate(SBG_MODE0, 1'b1, 1'b1, SBG_PHASES_PER_CYCLE);
    rate(SBG_MODE2, 1'b0, 1'b0, SBG_MODE2_DIV);
    rate(SBG_MODE2, 1'b0, 1'b1, SBG_MODE2_DIV / 2);
    rate(SBG_MODE1, 1'b1, 1'b0, SBG_GEN_FINAL_DIV);
    rate(SBG_MODE3, 1'b1, 1'b1, SBG_GEN_FINAL_DIV / 2);
    rate(SBG_MODE1, 1'b0, 1'b0, 4 * SBG_TMR_DIV);
    rate(SBG_MODE3, 1'b0, 1'b1, 2 * SBG_TMR_DIV);
    close_out();
  end
  // Watchdog: the whole run needs under 40000 cycles
  initial begin
    repeat (40000) @(posedge ref_clk);
    error_cnt++;
    close_out();
  end
endmodule
`default_nettype wire
